// file: hdl/gpg_pad_sense.sv
/*
  Per-pin sense logic: applies polarity, detects the selected sense
  condition and enforces the dead time after each event.
  Assumes level_sync comes from a synchroniser on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gpg_pad_sense
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       level_sync,
  input  wire logic       polarity_flip,
  input  wire logic [2:0] sense_config,
  output var  logic       level_out,
  output var  logic       event_out
);

  logic       prev_q;
  logic       prev_d;
  logic [1:0] hold_q;
  logic [1:0] hold_d;
  logic       level;
  logic       cond;

  // ==========================================================================
  // Logical level and sense condition.
  always_comb
  begin
    level = level_sync ^ polarity_flip;
    unique case (sense_config)
      gpg_pkg::SENSE_BOTH_EDGES: cond = level ^ prev_q;
      gpg_pkg::SENSE_RISING:     cond = level & ~prev_q;
      gpg_pkg::SENSE_FALLING:    cond = ~level & prev_q;
      gpg_pkg::SENSE_LOW_LEVEL:  cond = ~level;
      default:                   cond = 1'b0;
    endcase
    event_out = cond && (hold_q == 2'h0);
    prev_d    = level;
    if (event_out)
    begin
      hold_d = gpg_pkg::HOLDOFF_LOAD;
    end
    else if (hold_q != 2'h0)
    begin
      hold_d = hold_q - 2'h1;
    end
    else
    begin
      hold_d = hold_q;
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_q <= 1'b0;
      hold_q <= 2'h0;
    end
    else
    begin
      prev_q <= prev_d;
      hold_q <= hold_d;
    end
  end

  assign level_out = level;

endmodule

`default_nettype wire

// file: hdl/gpg_pkg.sv
/*
  Constants for the general-purpose pin group: register offsets, field
  positions, reset values, sense codes and the interrupt hold-off count.
  Assumes a byte-wide register port and an eight-pin group.
*/
`default_nettype none

package gpg_pkg;

  // ==========================================================================
  // Register offsets on the byte-wide register port.
  localparam logic [4:0] OFF_DRIVE_ENABLE   = 5'h00;
  localparam logic [4:0] OFF_DRIVE_SET      = 5'h01;
  localparam logic [4:0] OFF_DRIVE_CLEAR    = 5'h02;
  localparam logic [4:0] OFF_DRIVE_TOGGLE   = 5'h03;
  localparam logic [4:0] OFF_LEVEL          = 5'h04;
  localparam logic [4:0] OFF_LEVEL_SET      = 5'h05;
  localparam logic [4:0] OFF_LEVEL_CLEAR    = 5'h06;
  localparam logic [4:0] OFF_LEVEL_TOGGLE   = 5'h07;
  localparam logic [4:0] OFF_INPUT          = 5'h08;
  localparam logic [4:0] OFF_EVENT_FLAGS    = 5'h09;
  localparam logic [4:0] OFF_GROUP_CONTROL  = 5'h0a;
  localparam logic [4:0] OFF_STAGED_SETTING = 5'h0b;
  localparam logic [4:0] OFF_STAGED_COPY    = 5'h0c;
  localparam logic [4:0] OFF_STAGED_OR      = 5'h0d;
  localparam logic [4:0] OFF_STAGED_ANDNOT  = 5'h0e;
  localparam logic [4:0] OFF_PER_PAD_BASE   = 5'h10;

  // ==========================================================================
  // Fast alias locations.
  localparam logic [1:0] ALIAS_DRIVE_ENABLE = 2'h0;
  localparam logic [1:0] ALIAS_LEVEL        = 2'h1;
  localparam logic [1:0] ALIAS_INPUT        = 2'h2;
  localparam logic [1:0] ALIAS_EVENT_FLAGS  = 2'h3;

  // ==========================================================================
  // Fields of per_pad_control and group_control.
  localparam int         POS_POLARITY_FLIP    = 7;
  localparam int         POS_THRESHOLD_SELECT = 6;
  localparam int         POS_WEAK_HIGH        = 3;
  localparam int         POS_SENSE_LSB        = 0;
  localparam int         POS_EDGE_RATE_LIMIT  = 0;
  localparam logic [7:0] PAD_CTRL_MASK        = 8'hcf;
  localparam logic [7:0] PAD_CTRL_RESET       = 8'h00;
  localparam logic [7:0] REG_RESET            = 8'h00;

  // ==========================================================================
  // Sense configuration codes.
  localparam logic [2:0] SENSE_INT_DISABLE = 3'h0;
  localparam logic [2:0] SENSE_BOTH_EDGES  = 3'h1;
  localparam logic [2:0] SENSE_RISING      = 3'h2;
  localparam logic [2:0] SENSE_FALLING     = 3'h3;
  localparam logic [2:0] SENSE_BUFFER_OFF  = 3'h4;
  localparam logic [2:0] SENSE_LOW_LEVEL   = 3'h5;

  // ==========================================================================
  // Interrupt dead time after a pin event, in peripheral clock cycles.
  localparam int         HOLDOFF_CYCLES = 3;
  localparam logic [1:0] HOLDOFF_LOAD   = 2'(HOLDOFF_CYCLES - 1);

endpackage

`default_nettype wire

// file: hdl/gpg_sync.sv
/*
  Two-stage input synchroniser with a hold enable.
  Assumes the pad level is asynchronous; while en is low both stages hold.
*/
`timescale 1ns/1ps
`default_nettype none

module gpg_sync
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic en,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // ==========================================================================
  // Next values.
  always_comb
  begin
    meta_d = en ? async_in : meta_q;
    sync_d = en ? meta_q : sync_q;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// file: hdl/gpg_top.sv
/*
  General-purpose pin group of eight pins: drive enable, output level with
  set, clear and toggle strobes, sampled input, per-pin control, staged
  multi-pin configuration, fast alias port, peripheral override and pin
  event flags with one interrupt request.
  Assumes a byte-wide register port, a shared staged setting register held
  outside the group, and pad cells that resolve the output enables.
*/
`timescale 1ns/1ps
`default_nettype none

module gpg_top
#(
  parameter int PINS = 8
)
(
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic [4:0]      reg_addr,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_wdata,
  output var  logic [7:0]      reg_rdata,
  input  wire logic [1:0]      alias_addr,
  input  wire logic            alias_wr,
  input  wire logic            alias_rd,
  input  wire logic [7:0]      alias_wdata,
  output var  logic [7:0]      alias_rdata,
  input  wire logic [7:0]      staged_setting_in,
  output var  logic            staged_setting_wr,
  output var  logic [7:0]      staged_setting_wdata,
  input  wire logic [PINS-1:0] periph_dir_own,
  input  wire logic [PINS-1:0] periph_dir,
  input  wire logic [PINS-1:0] periph_level_own,
  input  wire logic [PINS-1:0] periph_level,
  output var  logic [PINS-1:0] periph_pin_level,
  input  wire logic [PINS-1:0] pad_in,
  output var  logic [PINS-1:0] pad_out,
  output var  logic [PINS-1:0] pad_oe_n,
  output var  logic [PINS-1:0] pad_pullup_en,
  output var  logic [PINS-1:0] pad_input_en,
  output var  logic [PINS-1:0] pad_ttl_sel,
  output var  logic            pad_slew_limit,
  output var  logic            irq
);

  logic [PINS-1:0] drive_q;
  logic [PINS-1:0] drive_d;
  logic [PINS-1:0] level_q;
  logic [PINS-1:0] level_d;
  logic [PINS-1:0] flags_q;
  logic [PINS-1:0] flags_d;
  logic            slew_q;
  logic            slew_d;
  logic [7:0]      pad_ctrl_q [PINS];
  logic [7:0]      pad_ctrl_d [PINS];
  logic [7:0]      rdata_q;
  logic [7:0]      rdata_d;
  logic [7:0]      ardata_q;
  logic [7:0]      ardata_d;
  logic [PINS-1:0] in_sync;
  logic [PINS-1:0] in_level;
  logic [PINS-1:0] pin_event;
  logic [PINS-1:0] flag_clear;
  logic [PINS-1:0] irq_enabled;
  logic [PINS-1:0] eff_drive;
  logic [PINS-1:0] wmask;
  logic [PINS-1:0] amask;

  // ==========================================================================
  // Helpers.
  function automatic logic [2:0] sense_of(input logic [7:0] ctrl);
    sense_of = ctrl[gpg_pkg::POS_SENSE_LSB +: 3];
  endfunction

  function automatic logic buffer_on(input logic [7:0] ctrl);
    buffer_on = (sense_of(ctrl) != gpg_pkg::SENSE_BUFFER_OFF);
  endfunction

  function automatic logic [7:0] widen(input logic [PINS-1:0] v);
    widen = 8'(v);
  endfunction

  assign wmask = reg_wdata[PINS-1:0];
  assign amask = alias_wdata[PINS-1:0];

  // ==========================================================================
  // Input path per pin.
  for (genvar n = 0; n < PINS; n++)
  begin : g_pin
    gpg_sync u_sync
    (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .en       (buffer_on(pad_ctrl_q[n])),
      .async_in (pad_in[n]),
      .sync_out (in_sync[n])
    );

    gpg_pad_sense u_sense
    (
      .clk           (clk),
      .sys_rst       (sys_rst),
      .level_sync    (in_sync[n]),
      .polarity_flip (pad_ctrl_q[n][gpg_pkg::POS_POLARITY_FLIP]),
      .sense_config  (sense_of(pad_ctrl_q[n])),
      .level_out     (in_level[n]),
      .event_out     (pin_event[n])
    );
  end

  // ==========================================================================
  // Drive enable and output level registers.
  always_comb
  begin
    drive_d = drive_q;
    level_d = level_q;
    slew_d  = slew_q;
    if (reg_wr)
    begin
      unique case (reg_addr)
        gpg_pkg::OFF_DRIVE_ENABLE:  drive_d = wmask;
        gpg_pkg::OFF_DRIVE_SET:     drive_d = drive_q | wmask;
        gpg_pkg::OFF_DRIVE_CLEAR:   drive_d = drive_q & ~wmask;
        gpg_pkg::OFF_DRIVE_TOGGLE:  drive_d = drive_q ^ wmask;
        gpg_pkg::OFF_LEVEL:         level_d = wmask;
        gpg_pkg::OFF_LEVEL_SET:     level_d = level_q | wmask;
        gpg_pkg::OFF_LEVEL_CLEAR:   level_d = level_q & ~wmask;
        gpg_pkg::OFF_LEVEL_TOGGLE:  level_d = level_q ^ wmask;
        gpg_pkg::OFF_INPUT:         level_d = level_q ^ wmask;
        gpg_pkg::OFF_GROUP_CONTROL: slew_d = reg_wdata[gpg_pkg::POS_EDGE_RATE_LIMIT];
        default:
        begin
        end
      endcase
    end
    // Alias writes are applied on top of an ordinary write in the same cycle.
    if (alias_wr)
    begin
      unique case (alias_addr)
        gpg_pkg::ALIAS_DRIVE_ENABLE: drive_d = amask;
        gpg_pkg::ALIAS_LEVEL:        level_d = amask;
        gpg_pkg::ALIAS_INPUT:        level_d = level_d ^ amask;
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drive_q <= '0;
      level_q <= '0;
      slew_q  <= 1'b0;
    end
    else
    begin
      drive_q <= drive_d;
      level_q <= level_d;
      slew_q  <= slew_d;
    end
  end

  // ==========================================================================
  // Per-pad control and staged multi-pin update.
  always_comb
  begin
    staged_setting_wr    = reg_wr && (reg_addr == gpg_pkg::OFF_STAGED_SETTING);
    staged_setting_wdata = reg_wdata & gpg_pkg::PAD_CTRL_MASK;
    for (int n = 0; n < PINS; n++)
    begin
      pad_ctrl_d[n] = pad_ctrl_q[n];
      if (reg_wr)
      begin
        if (reg_addr == (gpg_pkg::OFF_PER_PAD_BASE + 5'(n)))
        begin
          pad_ctrl_d[n] = reg_wdata & gpg_pkg::PAD_CTRL_MASK;
        end
        else if (reg_addr == gpg_pkg::OFF_STAGED_COPY && wmask[n])
        begin
          pad_ctrl_d[n] = staged_setting_in & gpg_pkg::PAD_CTRL_MASK;
        end
        else if (reg_addr == gpg_pkg::OFF_STAGED_OR && wmask[n])
        begin
          pad_ctrl_d[n] = (pad_ctrl_q[n] | staged_setting_in) & gpg_pkg::PAD_CTRL_MASK;
        end
        else if (reg_addr == gpg_pkg::OFF_STAGED_ANDNOT && wmask[n])
        begin
          pad_ctrl_d[n] = pad_ctrl_q[n] & ~staged_setting_in;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int n = 0; n < PINS; n++)
      begin
        pad_ctrl_q[n] <= gpg_pkg::PAD_CTRL_RESET;
      end
    end
    else
    begin
      for (int n = 0; n < PINS; n++)
      begin
        pad_ctrl_q[n] <= pad_ctrl_d[n];
      end
    end
  end

  // ==========================================================================
  // Event flags: write one to clear, a new event wins over the clear.
  always_comb
  begin
    flag_clear = '0;
    if (reg_wr && reg_addr == gpg_pkg::OFF_EVENT_FLAGS)
    begin
      flag_clear = wmask;
    end
    if (alias_wr && alias_addr == gpg_pkg::ALIAS_EVENT_FLAGS)
    begin
      flag_clear = flag_clear | amask;
    end
    flags_d = (flags_q & ~flag_clear) | pin_event;
    for (int n = 0; n < PINS; n++)
    begin
      irq_enabled[n] = (sense_of(pad_ctrl_q[n]) != gpg_pkg::SENSE_INT_DISABLE)
                       && buffer_on(pad_ctrl_q[n]);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_q <= '0;
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  assign irq = |(flags_q & irq_enabled);

  // ==========================================================================
  // Read data, one cycle after the read strobe.
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      unique case (reg_addr)
        gpg_pkg::OFF_DRIVE_ENABLE,
        gpg_pkg::OFF_DRIVE_SET,
        gpg_pkg::OFF_DRIVE_CLEAR,
        gpg_pkg::OFF_DRIVE_TOGGLE:   rdata_d = widen(drive_q);
        gpg_pkg::OFF_LEVEL,
        gpg_pkg::OFF_LEVEL_SET,
        gpg_pkg::OFF_LEVEL_CLEAR,
        gpg_pkg::OFF_LEVEL_TOGGLE:   rdata_d = widen(level_q);
        gpg_pkg::OFF_INPUT:          rdata_d = widen(in_level);
        gpg_pkg::OFF_EVENT_FLAGS:    rdata_d = widen(flags_q);
        gpg_pkg::OFF_GROUP_CONTROL:  rdata_d = {7'h00, slew_q};
        gpg_pkg::OFF_STAGED_SETTING: rdata_d = staged_setting_in & gpg_pkg::PAD_CTRL_MASK;
        default:
        begin
          rdata_d = gpg_pkg::REG_RESET;
          if (reg_addr[4] && (int'(reg_addr[3:0]) < PINS))
          begin
            rdata_d = pad_ctrl_q[reg_addr[2:0]];
          end
        end
      endcase
    end
    ardata_d = ardata_q;
    if (alias_rd)
    begin
      unique case (alias_addr)
        gpg_pkg::ALIAS_DRIVE_ENABLE: ardata_d = widen(drive_q);
        gpg_pkg::ALIAS_LEVEL:        ardata_d = widen(level_q);
        gpg_pkg::ALIAS_INPUT:        ardata_d = widen(in_level);
        gpg_pkg::ALIAS_EVENT_FLAGS:  ardata_d = widen(flags_q);
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_q  <= gpg_pkg::REG_RESET;
      ardata_q <= gpg_pkg::REG_RESET;
    end
    else
    begin
      rdata_q  <= rdata_d;
      ardata_q <= ardata_d;
    end
  end

  assign reg_rdata   = rdata_q;
  assign alias_rdata = ardata_q;

  // ==========================================================================
  // Pad controls with peripheral override.
  always_comb
  begin
    for (int n = 0; n < PINS; n++)
    begin
      eff_drive[n] = periph_dir_own[n] ? periph_dir[n] : drive_q[n];
      pad_oe_n[n]  = ~eff_drive[n];
      pad_out[n]   = periph_level_own[n] ? periph_level[n]
                     : (level_q[n] ^ pad_ctrl_q[n][gpg_pkg::POS_POLARITY_FLIP]);
      pad_pullup_en[n] = pad_ctrl_q[n][gpg_pkg::POS_WEAK_HIGH] & ~eff_drive[n];
      pad_input_en[n]  = buffer_on(pad_ctrl_q[n]);
      pad_ttl_sel[n]   = pad_ctrl_q[n][gpg_pkg::POS_THRESHOLD_SELECT];
    end
  end

  assign periph_pin_level = in_level;
  assign pad_slew_limit   = slew_q;

endmodule

`default_nettype wire

// file: verif/gpg_pad_model.sv
/*
  Behavioural pads and board around one pin group.
  Assumes the bench says which pins it drives from outside and to what level.
*/
`timescale 1ns/1ps
`default_nettype none

module gpg_pad_model
(
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output var  logic [7:0] pad_in
);
  // A floating pin shows a level that flips every cycle.
  logic [7:0] float_q = 8'h00;

  always @(posedge clk)
    float_q <= ~float_q;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = float_q[i];
    end
  end
endmodule

`default_nettype wire

// file: verif/gpg_top_asserts.sv
/*
  Concurrent checks on the ports of the eight-pin group.
  Assumes one clock, clk, and the asynchronous active-high reset sys_rst.
*/
`timescale 1ns/1ps
`default_nettype none

module gpg_top_asserts
#(
  parameter int PINS = 8
)
(
  input wire logic            clk,
  input wire logic            sys_rst,
  input wire logic [4:0]      reg_addr,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_wdata,
  input wire logic [7:0]      reg_rdata,
  input wire logic [1:0]      alias_addr,
  input wire logic            alias_wr,
  input wire logic [7:0]      alias_wdata,
  input wire logic            staged_setting_wr,
  input wire logic [7:0]      staged_setting_wdata,
  input wire logic [PINS-1:0] periph_dir_own,
  input wire logic [PINS-1:0] pad_oe_n,
  input wire logic [PINS-1:0] pad_pullup_en,
  input wire logic [PINS-1:0] pad_input_en,
  input wire logic            pad_slew_limit,
  input wire logic            irq
);
  // ==========================================================================
  // Defaults.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Direction belongs to the group alone: no alias write, no peripheral claim.
  logic quiet;
  assign quiet = !alias_wr && (periph_dir_own == '0);

  // ==========================================================================
  // Properties.
  property p_reset_state;
    $fell(sys_rst) |-> pad_oe_n == '1 && pad_input_en == '1 && !irq;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("pins busy after reset");

  property p_drv_set;
    reg_wr && reg_addr == gpg_pkg::OFF_DRIVE_SET && quiet
      |=> (pad_oe_n & $past(reg_wdata[PINS-1:0])) == '0;
  endproperty
  a_drv_set: assert property (p_drv_set) else $error("driver not enabled");

  property p_drv_clr;
    reg_wr && reg_addr == gpg_pkg::OFF_DRIVE_CLEAR && quiet
      |=> (pad_oe_n & $past(reg_wdata[PINS-1:0])) == $past(reg_wdata[PINS-1:0]);
  endproperty
  a_drv_clr: assert property (p_drv_clr) else $error("driver not disabled");

  property p_drv_tgl;
    reg_wr && reg_addr == gpg_pkg::OFF_DRIVE_TOGGLE && quiet
      |=> (pad_oe_n ^ $past(pad_oe_n)) == $past(reg_wdata[PINS-1:0]);
  endproperty
  a_drv_tgl: assert property (p_drv_tgl) else $error("direction toggle wrong");

  property p_alias_drv;
    alias_wr && alias_addr == gpg_pkg::ALIAS_DRIVE_ENABLE && !reg_wr && periph_dir_own == '0
      |=> pad_oe_n == ~$past(alias_wdata[PINS-1:0]);
  endproperty
  a_alias_drv: assert property (p_alias_drv) else $error("alias drive write wrong");

  property p_slew;
    reg_wr && reg_addr == gpg_pkg::OFF_GROUP_CONTROL |=> pad_slew_limit == $past(reg_wdata[0]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew limit not applied");

  property p_staged;
    reg_wr && reg_addr == gpg_pkg::OFF_STAGED_SETTING
      |-> staged_setting_wr && staged_setting_wdata == (reg_wdata & 8'hcf);
  endproperty
  a_staged: assert property (p_staged) else $error("staged setting not passed on");

  property p_pull_off;
    (pad_pullup_en & ~pad_oe_n) == '0;
  endproperty
  a_pull_off: assert property (p_pull_off) else $error("pull-up on a driven pin");

  property p_irq_hold;
    irq && !reg_wr && !alias_wr |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("request dropped with flag set");

  property p_unmapped;
    reg_rd && reg_addr == 5'h0f |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("reserved offset reads nonzero");

  property p_buf_off;
    reg_wr && reg_addr == gpg_pkg::OFF_PER_PAD_BASE && reg_wdata[2:0] == gpg_pkg::SENSE_BUFFER_OFF
      |=> !pad_input_en[0];
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("input buffer still on");
endmodule

bind gpg_top gpg_top_asserts #(.PINS(PINS)) gpg_top_asserts_inst (.clk(clk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .alias_addr(alias_addr), .alias_wr(alias_wr), .alias_wdata(alias_wdata),
  .staged_setting_wr(staged_setting_wr), .staged_setting_wdata(staged_setting_wdata),
  .periph_dir_own(periph_dir_own), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
  .pad_input_en(pad_input_en), .pad_slew_limit(pad_slew_limit), .irq(irq));

`default_nettype wire

// file: verif/tb_gpg_top.sv
/*
  Self-checking bench for the eight-pin group.
  Assumes gpg_top, its checker and the pad model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_gpg_top;
  logic       clk, sys_rst, reg_wr, reg_rd, alias_wr, alias_rd, staged_wr, slew, irq;
  logic [4:0] reg_addr;
  logic [1:0] alias_addr;
  logic [7:0] reg_wdata, reg_rdata, alias_wdata, alias_rdata, staged_q, staged_wdata;
  logic [7:0] dir_own, dir_val, lvl_own, lvl_val, pin_level, pad_in, pad_out, pad_oe_n;
  logic [7:0] pull_en, input_en, ttl_sel, ext_en, ext_val;
  int         failures, checks_done;

  gpg_top gpg_top_inst (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .alias_addr(alias_addr),
    .alias_wr(alias_wr), .alias_rd(alias_rd), .alias_wdata(alias_wdata),
    .alias_rdata(alias_rdata), .staged_setting_in(staged_q), .staged_setting_wr(staged_wr),
    .staged_setting_wdata(staged_wdata), .periph_dir_own(dir_own), .periph_dir(dir_val),
    .periph_level_own(lvl_own), .periph_level(lvl_val), .periph_pin_level(pin_level),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pull_en),
    .pad_input_en(input_en), .pad_ttl_sel(ttl_sel), .pad_slew_limit(slew), .irq(irq));

  gpg_pad_model gpg_pad_model_inst (.clk(clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pull_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // Shared staged setting register that sits outside the group.
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      staged_q <= 8'h00;
    else if (staged_wr)
      staged_q <= staged_wdata;

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // Access tasks.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One access on the register or alias port; a read is compared with d.
  task automatic acc(input logic al, input logic w, input logic [4:0] a, input logic [7:0] d);
    reg_addr = a;
    alias_addr = a[1:0];
    reg_wdata = d;
    alias_wdata = d;
    reg_wr = !al && w;
    reg_rd = !al && !w;
    alias_wr = al && w;
    alias_rd = al && !w;
    @(negedge clk);
    {reg_wr, reg_rd, alias_wr, alias_rd} = 4'h0;
    if (!w)
      chk(al ? alias_rdata : reg_rdata, d);
    @(negedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] d);
    acc(1'b0, 1'b0, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    chk(pad_oe_n, 8'hff);
    chk(input_en, 8'hff);
    rd(gpg_pkg::OFF_DRIVE_ENABLE, 8'h00);
    for (int i = 0; i < 8; i++)
      rd(5'h10 + 5'(i), 8'h00);
    wr(5'h0f, 8'hff);
    rd(5'h0f, 8'h00);
    rd(5'h18, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_drive;
    wr(gpg_pkg::OFF_DRIVE_SET, 8'h05);
    rd(gpg_pkg::OFF_DRIVE_ENABLE, 8'h05);
    wr(gpg_pkg::OFF_DRIVE_CLEAR, 8'h01);
    rd(gpg_pkg::OFF_DRIVE_ENABLE, 8'h04);
    wr(gpg_pkg::OFF_DRIVE_TOGGLE, 8'h0c);
    chk(pad_oe_n, 8'hf7);
    $display("drive test done");
  endtask

  task automatic t_level;
    wr(gpg_pkg::OFF_DRIVE_ENABLE, 8'hff);
    wr(gpg_pkg::OFF_LEVEL_SET, 8'ha5);
    wr(gpg_pkg::OFF_LEVEL_CLEAR, 8'h05);
    rd(gpg_pkg::OFF_LEVEL, 8'ha0);
    wr(gpg_pkg::OFF_LEVEL_TOGGLE, 8'h0f);
    wr(gpg_pkg::OFF_INPUT, 8'hff);
    rd(gpg_pkg::OFF_LEVEL, 8'h50);
    rd(gpg_pkg::OFF_INPUT, 8'h50);
    wr(5'h11, 8'h80);
    chk(pad_out, 8'h52);
    idle(3);
    rd(gpg_pkg::OFF_INPUT, 8'h50);
    wr(gpg_pkg::OFF_LEVEL_SET, 8'h02);
    chk(pad_out, 8'h50);
    wr(5'h11, 8'h00);
    wr(gpg_pkg::OFF_LEVEL, 8'h3c);
    acc(1'b1, 1'b1, 5'(gpg_pkg::ALIAS_INPUT), 8'h0f);
    acc(1'b1, 1'b0, 5'(gpg_pkg::ALIAS_LEVEL), 8'h33);
    acc(1'b1, 1'b1, 5'(gpg_pkg::ALIAS_DRIVE_ENABLE), 8'hf0);
    rd(gpg_pkg::OFF_DRIVE_ENABLE, 8'hf0);
    $display("level test done");
  endtask

  task automatic t_pad;
    wr(gpg_pkg::OFF_DRIVE_CLEAR, 8'hff);
    ext_en = 8'hfb;
    wr(5'h12, 8'h08);
    chk(pull_en, 8'h04);
    wr(gpg_pkg::OFF_DRIVE_SET, 8'h04);
    chk(pull_en, 8'h00);
    wr(gpg_pkg::OFF_DRIVE_CLEAR, 8'h04);
    ext_en = 8'hff;
    wr(5'h13, 8'h40);
    chk(ttl_sel, 8'h08);
    wr(5'h14, 8'hff);
    rd(5'h14, 8'hcf);
    wr(gpg_pkg::OFF_GROUP_CONTROL, 8'h01);
    chk({7'h00, slew}, 8'h01);
    wr(gpg_pkg::OFF_GROUP_CONTROL, 8'h00);
    chk({7'h00, slew}, 8'h00);
    $display("pad control test done");
  endtask

  task automatic t_staged;
    wr(gpg_pkg::OFF_STAGED_SETTING, 8'hff);
    rd(gpg_pkg::OFF_STAGED_SETTING, 8'hcf);
    wr(gpg_pkg::OFF_STAGED_SETTING, 8'h4a);
    wr(gpg_pkg::OFF_STAGED_COPY, 8'h30);
    rd(5'h15, 8'h4a);
    rd(5'h16, 8'h00);
    wr(gpg_pkg::OFF_STAGED_SETTING, 8'h81);
    wr(gpg_pkg::OFF_STAGED_OR, 8'h10);
    rd(5'h14, 8'hcb);
    rd(5'h15, 8'h4a);
    wr(gpg_pkg::OFF_STAGED_SETTING, 8'h0a);
    wr(gpg_pkg::OFF_STAGED_ANDNOT, 8'h30);
    rd(5'h14, 8'hc1);
    rd(5'h15, 8'h40);
    wr(gpg_pkg::OFF_STAGED_SETTING, 8'hff);
    wr(gpg_pkg::OFF_STAGED_ANDNOT, 8'hff);
    rd(5'h13, 8'h00);
    $display("staged test done");
  endtask

  task automatic t_sense;
    logic [2:0] codes [4];
    codes = '{gpg_pkg::SENSE_INT_DISABLE, gpg_pkg::SENSE_BOTH_EDGES,
              gpg_pkg::SENSE_FALLING, gpg_pkg::SENSE_LOW_LEVEL};
    ext_val = 8'h00;
    wr(5'h10, {5'h00, gpg_pkg::SENSE_RISING});
    wr(gpg_pkg::OFF_EVENT_FLAGS, 8'hff);
    chk({7'h00, irq}, 8'h00);
    ext_val = 8'h01;
    for (int n = 0; n < 8 && irq !== 1'b1; n++)
      @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    rd(gpg_pkg::OFF_EVENT_FLAGS, 8'h01);
    wr(gpg_pkg::OFF_EVENT_FLAGS, 8'h01);
    chk({7'h00, irq}, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      ext_val = 8'h01;
      wr(5'h10, {5'h00, codes[i]});
      idle(4);
      wr(gpg_pkg::OFF_EVENT_FLAGS, 8'hff);
      ext_val = 8'h00;
      idle(5);
      chk({7'h00, irq}, (i == 0) ? 8'h00 : 8'h01);
    end
    wr(5'h10, {5'h00, gpg_pkg::SENSE_RISING});
    idle(4);
    wr(gpg_pkg::OFF_EVENT_FLAGS, 8'hff);
    wr(5'h10, {5'h10, gpg_pkg::SENSE_RISING});
    wr(5'h10, {5'h10, gpg_pkg::SENSE_RISING} | 8'h80);
    idle(4);
    chk({7'h00, irq}, 8'h01);
    wr(5'h10, {5'h00, gpg_pkg::SENSE_BUFFER_OFF});
    wr(gpg_pkg::OFF_EVENT_FLAGS, 8'hff);
    chk(input_en, 8'hfe);
    ext_val = 8'h01;
    idle(4);
    rd(gpg_pkg::OFF_INPUT, 8'h00);
    $display("sense test done");
  endtask

  task automatic t_override;
    {dir_own, dir_val, lvl_own, lvl_val} = {4{8'h80}};
    idle(3);
    chk(pad_oe_n, 8'h7f);
    chk(pin_level & 8'h80, 8'h80);
    chk(pad_out & 8'h80, 8'h80);
    {dir_own, dir_val, lvl_own, lvl_val} = 32'h0;
    $display("override test done");
  endtask

  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence and watchdog.
  initial
  begin
    {reg_wr, reg_rd, alias_wr, alias_rd, reg_addr, alias_addr} = 11'h0;
    {reg_wdata, alias_wdata, dir_own, dir_val, lvl_own, lvl_val} = 48'h0;
    ext_en = 8'hff;
    ext_val = 8'h00;
    failures = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_drive();
    t_level();
    t_pad();
    t_staged();
    t_sense();
    t_override();
    close_out();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule

`default_nettype wire
